/* common/xcl_pkg.sv */
// constants shared by the crosspoint configuration loader
`default_nettype none

package xcl_pkg;

   // =====================================================
   // matrix geometry
   localparam int NUM_OUT = 16;
   localparam int SEL_W = 5;
   localparam int FIELD_W = 6;
   localparam int FRAME_BITS = NUM_OUT * FIELD_W;
   localparam int OUT_IDX_W = 4;

   // =====================================================
   // field layout inside one serial-mode output slot
   localparam int FIELD_SEL_LSB = 0;
   localparam int FIELD_HIZ_BIT = 5;

   // =====================================================
   // addressed-mode word layout
   localparam int WORD_BITS = 10;
   localparam int WORD_OUT_LSB = 0;
   localparam int WORD_SEL_LSB = 4;
   localparam int WORD_HIZ_BIT = 9;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] WORD_BITS_CNT = 4'hA;

   // =====================================================
   // forced and reset settings of one output slot
   localparam logic [FIELD_W-1:0] FIELD_RESET = 6'h20; // input 0, high impedance
   localparam logic [FIELD_W-1:0] FIELD_BCAST = 6'h00; // input 0, driven
   localparam logic [FIELD_W-1:0] FIELD_CLEAR = 6'h00;

   // =====================================================
   // pin synchroniser reset levels
   localparam logic PIN_IDLE_LOW = 1'b0;
   localparam logic PIN_IDLE_HIGH = 1'b1;

   // =====================================================
   // serial link framing state
   typedef enum logic [0:0] {
      XCL_IDLE = 1'b0,
      XCL_ARMED = 1'b1
   } xcl_link_t;

endpackage : xcl_pkg

`default_nettype wire

/* rtl/xcl_loader.sv */
// serial configuration loader for a 32-input, 16-output crosspoint switch
//
// Contract
// [R1] serial frame: 96 bits, slot k = bits 6k..6k+5, select LSB first, then off bit
// [R2] mode high: each word updates only the named pending slot
// [R3] addressed word LSB first: out 0-3, select 4-8, bit 9 high impedance
// [R4] host lowers select before first rising clock; first bit on next fall
// [R5] host raises select after last bit, then one more rising clock
// [R6] host changes select only while serial clock is low
// [R7] host keeps configure low until all bits are shifted in
// [R8] chaining only in serial mode, serial out feeds next serial in
// [R9] serial out shows old contents; after 96 bits new frame bits pass on
// [R10] two chained devices: host shifts 192 clocks then raises select
// [R11] shared configure pulse applies chained devices together, or separately
// [R12] reset pin high: every output select 0 and high impedance
// [R13] broadcast pin high: every output on, connected to input 0
// [R14] reset and broadcast act by level without serial clock
// [R15] reset or broadcast overwrite stored active configuration
// [R16] configure high pulse copies pending to active; repeats without data do nothing
// [R17] select high: serial data and clock ignored
// [R18] serial data sampled on falling serial clock edge
// [R19] serial load register shifts; extra bits push intended data out
// [R20] reset and broadcast together: reset wins, outputs disabled
// [R21] addressed mode uses last ten bits; incomplete word ignored
`default_nettype none

module xcl_loader (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic serialClk,
   input wire logic chipSelectN,
   input wire logic serialIn,
   input wire logic addressedMode,
   input wire logic configStrobe,
   input wire logic resetPin,
   input wire logic force_all_to_input_zero,
   output logic serialOut,
   output logic [xcl_pkg::NUM_OUT-1:0][xcl_pkg::SEL_W-1:0] outSelect,
   output logic [xcl_pkg::NUM_OUT-1:0] outHighZ,
   output logic pendingValid
);

   // =====================================================
   // synchronised pins
   // limitation: every pin acts three clocks late, so a host must pace its edges
   logic clkS;
   logic csNS;
   logic dinS;
   logic modeS;
   logic cfgS;
   logic rstS;
   logic bcstS;

   // serial clock is sampled as data; each level must stand four clocks
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncClk (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(serialClk),
      .pinSync(clkS)
   );

   // select idles high so nothing is taken straight after reset
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_HIGH)) uSyncCs (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(chipSelectN),
      .pinSync(csNS)
   );

   // data shares the clock's two-flop delay so both line up at the edge
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncDin (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(serialIn),
      .pinSync(dinS)
   );

   // mode only matters at a falling edge or at select rise
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncMode (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(addressedMode),
      .pinSync(modeS)
   );

   // strobe rise is found after the two flops, two clocks after the pin
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncCfg (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(configStrobe),
      .pinSync(cfgS)
   );

   // forcing pins are levels; the two flops only add latency
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncRst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(resetPin),
      .pinSync(rstS)
   );

   // broadcast pin, same treatment as the reset pin
   xcl_sync #(.RESET_VAL(xcl_pkg::PIN_IDLE_LOW)) uSyncBcst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pinAsync(force_all_to_input_zero),
      .pinSync(bcstS)
   );

   // =====================================================
   // edge detection on synchronised levels
   logic clkPrev_reg;
   logic clkPrev_next;
   logic csPrev_reg;
   logic csPrev_next;
   logic cfgPrev_reg;
   logic cfgPrev_next;
   logic clkRise;
   logic clkFall;
   logic csRise;
   logic cfgRise;

   // previous levels; reset values match the idle pins so no false edge follows
   always_comb begin
      clkPrev_next = clkS;
      csPrev_next = csNS;
      cfgPrev_next = cfgS;
      if (!resetn) begin
         clkPrev_next = xcl_pkg::PIN_IDLE_LOW;
         csPrev_next = xcl_pkg::PIN_IDLE_HIGH;
         cfgPrev_next = xcl_pkg::PIN_IDLE_LOW;
      end
   end

   // registers
   always_ff @(posedge ref_clk) begin
      clkPrev_reg <= clkPrev_next;
      csPrev_reg <= csPrev_next;
      cfgPrev_reg <= cfgPrev_next;
   end

   // one-cycle edge pulses
   assign clkRise = clkS && !clkPrev_reg;
   assign clkFall = !clkS && clkPrev_reg;
   assign csRise = csNS && !csPrev_reg;
   assign cfgRise = cfgS && !cfgPrev_reg;

   // =====================================================
   // slot access helpers
   function automatic logic [xcl_pkg::FIELD_W-1:0] getSlot(
      input logic [xcl_pkg::FRAME_BITS-1:0] frame,
      input int unsigned idx
   );
      getSlot = frame[idx*xcl_pkg::FIELD_W +: xcl_pkg::FIELD_W];
   endfunction : getSlot

   // builds one slot from an addressed word
   function automatic logic [xcl_pkg::FIELD_W-1:0] wordSlot(
      input logic [xcl_pkg::WORD_BITS-1:0] word
   );
      logic [xcl_pkg::FIELD_W-1:0] slot;
      slot = xcl_pkg::FIELD_CLEAR;
      slot[xcl_pkg::FIELD_SEL_LSB +: xcl_pkg::SEL_W] =
         word[xcl_pkg::WORD_SEL_LSB +: xcl_pkg::SEL_W];
      slot[xcl_pkg::FIELD_HIZ_BIT] = word[xcl_pkg::WORD_HIZ_BIT];
      wordSlot = slot;
   endfunction : wordSlot

   // =====================================================
   // serial link: framing, load register, word register
   xcl_pkg::xcl_link_t link_reg;
   xcl_pkg::xcl_link_t link_next;
   logic [xcl_pkg::FRAME_BITS-1:0] load_reg;
   logic [xcl_pkg::FRAME_BITS-1:0] load_next;
   logic [xcl_pkg::WORD_BITS-1:0] word_reg;
   logic [xcl_pkg::WORD_BITS-1:0] word_next;
   logic [xcl_pkg::CNT_W-1:0] wordCnt_reg;
   logic [xcl_pkg::CNT_W-1:0] wordCnt_next;
   logic dout_reg;
   logic dout_next;
   logic fresh_reg;
   logic fresh_next;
   logic [xcl_pkg::OUT_IDX_W-1:0] wordOut;

   // output number of the addressed word
   assign wordOut = word_reg[xcl_pkg::WORD_OUT_LSB +: xcl_pkg::OUT_IDX_W];

   // next values of the link side; select high returns the link to idle
   always_comb begin
      link_next = link_reg;
      load_next = load_reg;
      word_next = word_reg;
      wordCnt_next = wordCnt_reg;
      dout_next = dout_reg;
      fresh_next = fresh_reg;
      // a strobe consumes the pending data, but data landing in the same
      // cycle sets the flag again below so it waits for the next strobe
      if (cfgRise) begin // R16
         fresh_next = 1'b0;
      end
      unique case (link_reg)
         xcl_pkg::XCL_IDLE: begin
            // a rising clock with select low arms the first falling edge
            if (!csNS && clkRise) begin // R4
               link_next = xcl_pkg::XCL_ARMED;
               wordCnt_next = '0;
            end
         end
         xcl_pkg::XCL_ARMED: begin
            // select high drops the frame; a new one needs a new arming rise
            if (csNS) begin // R17
               link_next = xcl_pkg::XCL_IDLE;
            end else if (clkFall) begin // R18
               if (!modeS) begin
                  // bit 0 enters first and ends at the low end after 96 shifts
                  dout_next = load_reg[0]; // R8 R9
                  load_next = {dinS, load_reg[xcl_pkg::FRAME_BITS-1:1]}; // R1 R19
                  fresh_next = 1'b1;
               end else begin
                  word_next = {dinS, word_reg[xcl_pkg::WORD_BITS-1:1]}; // R3
                  // count saturates: a longer word still qualifies, the last ten stay
                  if (wordCnt_reg != xcl_pkg::WORD_BITS_CNT) begin
                     wordCnt_next = wordCnt_reg + 1'b1;
                  end
               end
            end
         end
      endcase
      // addressed word lands in its pending slot once select closes the word
      if (link_reg == xcl_pkg::XCL_ARMED && csRise && modeS
          && wordCnt_reg == xcl_pkg::WORD_BITS_CNT) begin // R21
         load_next[wordOut*xcl_pkg::FIELD_W +: xcl_pkg::FIELD_W] = wordSlot(word_reg); // R2
         fresh_next = 1'b1;
      end
      // forcing pins are levels and clear the pending flag; the load register keeps its bits
      if (rstS || bcstS) begin // R15
         fresh_next = 1'b0;
      end
      if (!resetn) begin
         link_next = xcl_pkg::XCL_IDLE;
         load_next = '0;
         word_next = '0;
         wordCnt_next = '0;
         dout_next = 1'b0;
         fresh_next = 1'b0;
      end
   end

   // registers
   always_ff @(posedge ref_clk) begin
      link_reg <= link_next;
      load_reg <= load_next;
      word_reg <= word_next;
      wordCnt_reg <= wordCnt_next;
      dout_reg <= dout_next;
      fresh_reg <= fresh_next;
   end

   // =====================================================
   // active output registers, driving the matrix
   logic [xcl_pkg::NUM_OUT-1:0][xcl_pkg::FIELD_W-1:0] active_reg;
   logic [xcl_pkg::NUM_OUT-1:0][xcl_pkg::FIELD_W-1:0] active_next;

   // forcing pins are levels and hold the outputs as long as they stand
   always_comb begin
      active_next = active_reg;
      for (int k = 0; k < xcl_pkg::NUM_OUT; k++) begin
         if (rstS) begin // R12 R14 R20
            active_next[k] = xcl_pkg::FIELD_RESET;
         end else if (bcstS) begin // R13 R14
            active_next[k] = xcl_pkg::FIELD_BCAST;
         end else if (cfgRise && fresh_reg) begin // R16 R11
            active_next[k] = getSlot(load_reg, k);
         end
      end
      if (!resetn) begin
         for (int k = 0; k < xcl_pkg::NUM_OUT; k++) begin
            active_next[k] = xcl_pkg::FIELD_RESET;
         end
      end
   end

   // registers
   always_ff @(posedge ref_clk) begin
      active_reg <= active_next;
   end

   // =====================================================
   // outputs, all straight from flip-flops
   always_comb begin
      for (int k = 0; k < xcl_pkg::NUM_OUT; k++) begin
         outSelect[k] = active_reg[k][xcl_pkg::FIELD_SEL_LSB +: xcl_pkg::SEL_W];
         outHighZ[k] = active_reg[k][xcl_pkg::FIELD_HIZ_BIT];
      end
   end

   // chain output and pending flag, both registered
   assign serialOut = dout_reg;
   assign pendingValid = fresh_reg;

endmodule : xcl_loader

`default_nettype wire

/* rtl/xcl_sync.sv */
// two-flop synchroniser for one asynchronous pin
`default_nettype none

module xcl_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic pinAsync,
   output logic pinSync
);

   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   // =====================================================
   // next values: first stage only feeds the second
   always_comb begin
      meta_next = pinAsync;
      sync_next = meta_reg;
      if (!resetn) begin
         meta_next = RESET_VAL;
         sync_next = RESET_VAL;
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge ref_clk) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign pinSync = sync_reg;

endmodule : xcl_sync

`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the crosspoint configuration loader
`default_nettype none

// ====
// bench top
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, resetn, serialClk, chipSelectN, serialIn, addressedMode, configStrobe;
   logic resetPin, forceZero, serialOut, pendingValid;
   logic [xcl_pkg::NUM_OUT-1:0][xcl_pkg::SEL_W-1:0] outSelect;
   logic [xcl_pkg::NUM_OUT-1:0] outHighZ;
   int fails, n_checks;
   logic [31:0] seed = 32'h3835FD6E;
   bit q[$]; // model load register, entry 0 leaves next
   bit act[96];
   bit pv, qKnown;
   xcl_loader dut_u (.ref_clk, .resetn, .serialClk, .chipSelectN, .serialIn, .addressedMode,
      .configStrobe, .resetPin, .force_all_to_input_zero(forceZero), .serialOut, .outSelect,
      .outHighZ, .pendingValid);
   xcl_host host_u (.ref_clk, .serialClk, .chipSelectN, .serialIn);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, got);
      end
   endtask : cmp
   task automatic checkAll();
      int s;
      for (int k = 0; k < 16; k++) begin
         s = 0;
         for (int i = 0; i < 5; i++) s += int'(act[6*k+i]) << i;
         cmp({27'h0, outSelect[k]}, s);
         cmp({31'h0, outHighZ[k]}, act[6*k+5]);
      end
      cmp({31'h0, pendingValid}, pv);
   endtask : checkAll
   // frame of random bits; pending state is modelled as the device should keep it
   task automatic sendBits(input int n);
      bit b;
      int base, k;
      bit w[$];
      host_u.startFrame();
      repeat (n) begin
         b = 1'(rnd());
         host_u.sendBit(b);
         if (addressedMode) w.push_back(b);
         else begin
            if (qKnown) cmp({31'h0, serialOut}, q[0]);
            void'(q.pop_front());
            q.push_back(b);
            pv = 1;
         end
      end
      host_u.endFrame();
      if (!addressedMode && n >= 96) qKnown = 1;
      if (addressedMode && w.size() >= 10) begin
         base = w.size() - 10;
         k = w[base] + 2 * w[base+1] + 4 * w[base+2] + 8 * w[base+3];
         for (int j = 0; j < 6; j++) q[6*k+j] = w[base+4+j];
         pv = 1;
      end
   endtask : sendBits
   task automatic pulseCfg();
      configStrobe <= 1'b1;
      tick(6);
      configStrobe <= 1'b0;
      tick(6);
      if (pv) foreach (act[i]) act[i] = q[i];
      pv = 0;
   endtask : pulseCfg
   // forcing pins leave the load register alone, yet serial out is not trusted after
   task automatic forcePins(input logic r, input logic f);
      resetPin <= r;
      forceZero <= f;
      tick(6);
      foreach (act[i]) act[i] = (i % 6 == 5) ? r : 1'b0;
      pv = 0;
      qKnown = 0;
      checkAll();
      resetPin <= 1'b0;
      forceZero <= 1'b0;
      tick(6);
   endtask : forcePins
   task automatic finish_test();
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // main sequence
   initial begin
      resetn = 1'b0;
      addressedMode = 1'b0;
      configStrobe = 1'b0;
      resetPin = 1'b0;
      forceZero = 1'b0;
      repeat (96) q.push_back(1'b0);
      foreach (act[i]) act[i] = (i % 6 == 5);
      tick(6);
      resetn <= 1'b1;
      tick(4);
      checkAll();
      sendBits(96);
      pulseCfg();
      checkAll();
      sendBits(192);
      pulseCfg();
      checkAll();
      pulseCfg();
      checkAll();
      sendBits(90);
      forcePins(1'b0, 1'b1);
      pulseCfg();
      checkAll();
      forcePins(1'b1, 1'b0);
      forcePins(1'b1, 1'b1);
      addressedMode <= 1'b1;
      tick(6);
      for (int i = 0; i < 6; i++) begin
         sendBits(10 + i % 3 * 2);
         pulseCfg();
         checkAll();
      end
      sendBits(7);
      pulseCfg();
      checkAll();
      addressedMode <= 1'b0;
      tick(6);
      sendBits(100);
      pulseCfg();
      checkAll();
      finish_test();
   end
   // watchdog well past the roughly seven thousand cycles the run needs
   initial begin
      tick(20000);
      fails++;
      finish_test();
   end
endmodule : testbench

`default_nettype wire

/* verification/xcl_host.sv */
// serial host model that drives the loader's serial clock, select and data pins
`default_nettype none

// ====
// host side of the serial link
module xcl_host (
   input wire logic ref_clk,
   output logic serialClk,
   output logic chipSelectN,
   output logic serialIn
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 6; // each clock level must stand at least four cycles
   // idle line toggles every clock while deselected, so it shows a changing pattern rather than stale data
   initial begin
      serialClk = 1'b0;
      chipSelectN = 1'b1;
      serialIn = 1'b0;
   end
   always @(posedge ref_clk) if (chipSelectN) serialIn <= ~serialIn;
   task automatic waitHalf();
      repeat (HALF) @(posedge ref_clk);
   endtask : waitHalf
   // select falls while the clock is low, ahead of the arming rise
   task automatic startFrame();
      chipSelectN <= 1'b0;
      waitHalf();
   endtask : startFrame
   // data set at the rise so it is steady across the sampling fall
   task automatic sendBit(input logic b);
      serialIn <= b;
      serialClk <= 1'b1;
      waitHalf();
      serialClk <= 1'b0;
      waitHalf();
   endtask : sendBit
   // select rises with the clock low, then one more rising clock
   task automatic endFrame();
      chipSelectN <= 1'b1;
      waitHalf();
      serialClk <= 1'b1;
      waitHalf();
      serialClk <= 1'b0;
      waitHalf();
   endtask : endFrame
endmodule : xcl_host

`default_nettype wire

/* verification/xcl_loader_monitor.sv */
// assertion checker for the crosspoint configuration loader
`default_nettype none

// ====
// checker on the loader pins
module xcl_loader_monitor (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic chipSelectN,
   input wire logic addressedMode,
   input wire logic configStrobe,
   input wire logic resetPin,
   input wire logic force_all_to_input_zero,
   input wire logic serialOut,
   input wire logic [xcl_pkg::NUM_OUT-1:0][xcl_pkg::SEL_W-1:0] outSelect,
   input wire logic [xcl_pkg::NUM_OUT-1:0] outHighZ,
   input wire logic pendingValid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // pins pass two flops and an edge stage, so every window is four or six long
   sequence rstHeld; resetPin [*4]; endsequence
   sequence bcHeld; (force_all_to_input_zero && !resetPin) [*4]; endsequence
   sequence quiet; (!configStrobe && !resetPin && !force_all_to_input_zero) [*6]; endsequence
   sequence csIdle; chipSelectN [*6]; endsequence
   sequence cfgHi; $rose(configStrobe) && chipSelectN ##1 (configStrobe && chipSelectN) [*5];
   endsequence
   AST_RST_ALL: assert property (rstHeld |=> &outHighZ && outSelect == '0)
      else $error("reset pin did not force outputs off");
   AST_RST_WINS: assert property (rstHeld and force_all_to_input_zero [*4] |=> &outHighZ)
      else $error("broadcast overrode reset");
   AST_BCAST: assert property (bcHeld |=> outHighZ == '0 && outSelect == '0)
      else $error("broadcast did not drive all outputs from input 0");
   AST_PV_FORCE: assert property ((resetPin || force_all_to_input_zero) [*4]
      |=> !pendingValid)
      else $error("forced setting kept pending data");
   AST_QUIET: assert property (quiet |=> $stable(outSelect) && $stable(outHighZ))
      else $error("outputs moved without configure");
   AST_CS_IGNORE: assert property (csIdle |=> $stable(serialOut))
      else $error("serial out moved while deselected");
   AST_MODE_HOLD: assert property (addressedMode [*6] |=> $stable(serialOut))
      else $error("serial out shifted in addressed mode");
   AST_CFG_CLEAR: assert property (csIdle ##1 cfgHi |=> !pendingValid)
      else $error("configure left pending flag set");
endmodule : xcl_loader_monitor

bind xcl_loader xcl_loader_monitor mon_u (.ref_clk, .resetn, .chipSelectN, .addressedMode,
   .configStrobe, .resetPin, .force_all_to_input_zero, .serialOut, .outSelect, .outHighZ,
   .pendingValid);

`default_nettype wire
